/* File: design/fcp_pkg.sv */
/*
 * Package for the floating-point coprocessor port: bus widths, transfer
 * state encoding and constants shared by the processor end and unit end.
 * Assumes both ends run on one clock, sys_clk, with synchronous reset.
 */
package fcp_pkg;
    localparam int unsigned INSTR_W = 32;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned CC_W    = 2;

    localparam logic [INSTR_W-1:0] INSTR_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;
    localparam logic [CC_W-1:0]    CC_RST    = 2'h0;

    // Gray order along idle -> instr -> addr -> end
    typedef enum logic [1:0] {
        FCP_IDLE  = 2'h0,
        FCP_INSTR = 2'h1,
        FCP_ADDR  = 2'h3,
        FCP_END   = 2'h2
    } fcp_xfer_e;
endpackage

/* File: design/fcp_if.sv */
/*
 * Interface joining the processor end and the floating-point unit end.
 * The shared system data bus is a wired bus; its level is resolved here
 * from the two output enables (high while an end drives it).
 */
`timescale 1ns/1ps
interface fcp_if;
    import fcp_pkg::*;
    logic [INSTR_W-1:0] coproc_bus;
    logic               coproc_instr_valid;
    logic               coproc_addr_valid;
    logic               coproc_xfer_end;
    logic               data_fetch_ind;
    logic               fp_flush;
    logic               fp_exception_ack;
    logic [CC_W-1:0]    fp_cond_code;
    logic               fp_cond_code_valid;
    logic               fp_exception_req;
    logic               coproc_hold;
    logic               fpu_present;
    logic [DATA_W-1:0]  cpu_data_out;
    logic               cpu_data_oe;
    logic [DATA_W-1:0]  fpu_data_out;
    logic               fpu_data_oe;
    wire  [DATA_W-1:0]  sys_data;

    assign sys_data = fpu_data_oe ? fpu_data_out :
                      cpu_data_oe ? cpu_data_out : DATA_RST;

    modport cpu (
        output coproc_bus, coproc_instr_valid, coproc_addr_valid,
        output coproc_xfer_end, data_fetch_ind, fp_flush, fp_exception_ack,
        output cpu_data_out, cpu_data_oe,
        input  fp_cond_code, fp_cond_code_valid, fp_exception_req,
        input  coproc_hold, fpu_present, sys_data
    );
    modport fpu (
        input  coproc_bus, coproc_instr_valid, coproc_addr_valid,
        input  coproc_xfer_end, data_fetch_ind, fp_flush, fp_exception_ack,
        input  sys_data,
        output fp_cond_code, fp_cond_code_valid, fp_exception_req,
        output coproc_hold, fpu_present, fpu_data_out, fpu_data_oe
    );
endinterface

/* File: design/fcp_cpu_end.sv */
/*
 * Processor end of the floating-point coprocessor port. Sequences one
 * instruction transfer per request: instruction cycle, address cycle,
 * end cycle, stretched by the unit's hold and by memory hold.
 * Assumes all inputs are synchronous to sys_clk.
 */
// Summary of operation
// - Send instruction and address on coprocessor bus
// - Operand data uses shared system data bus
// - Instruction first cycle, address second cycle
// - Instruction-valid strobe during instruction cycle
// - Address-valid strobe during address cycle
// - Transfer-end strobe after the address cycle
// - Transfer-end marks last transfer cycle
// - Unit latches and keeps instruction address
// - Unit returns two-bit condition codes
// - Code meaningful only while valid asserted
// - Unit raises exception on request line
// - Processor acknowledges recognised floating exception
// - Hold stretches transfer until released
// - Flush makes unit abandon current instruction
// - Present input reflects attached unit
// - Data-fetch indication at start of memory ops
// - Memory ops: instruction then address cycles
// - Unit moves operand over system data bus
// - Miss and exception timing as integer
// - Memory hold pauses until access completes
// - Data strobe pulses during held fetch
// - Memory exception with hold then release both
// - Null cycle whenever any hold asserted
`timescale 1ns/1ps
module fcp_cpu_end (
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire logic                   clk_en,
    fcp_if.cpu                          port,
    input  wire logic                   xfer_req,
    input  wire logic                   xfer_is_mem,
    input  wire logic [fcp_pkg::INSTR_W-1:0] xfer_instr,
    input  wire logic [fcp_pkg::INSTR_W-1:0] xfer_addr,
    output logic                        xfer_ready,
    output logic                        xfer_done,
    input  wire logic                   flush_req,
    input  wire logic [fcp_pkg::DATA_W-1:0] store_data,
    input  wire logic                   store_data_oe,
    output logic [fcp_pkg::DATA_W-1:0]  load_data,
    input  wire logic                   memory_hold,
    input  wire logic                   memory_data_strobe,
    input  wire logic                   memory_exception,
    output logic                        null_cycle_ind,
    output logic [fcp_pkg::CC_W-1:0]    cond_code,
    output logic                        cond_code_ok,
    output logic                        fp_exception,
    output logic                        mem_exception,
    output logic                        unit_attached
);
    import fcp_pkg::*;

    fcp_xfer_e          state_q;
    fcp_xfer_e          state_d;
    logic [INSTR_W-1:0] addr_q;
    logic [INSTR_W-1:0] bus_q;
    logic [INSTR_W-1:0] bus_d;
    logic               mem_q;
    logic               fetch_q;
    logic               ack_q;
    logic               done_q;
    logic [CC_W-1:0]    cc_q;
    logic               ccv_q;
    logic [DATA_W-1:0]  load_q;
    logic               memory_exception_q;
    logic               flush_q;

    wire any_hold  = port.coproc_hold | memory_hold;
    wire advance   = clk_en & ~any_hold;
    wire start     = (state_q == FCP_IDLE) & xfer_req & port.fpu_present;

    always_comb begin
        state_d = state_q;
        bus_d   = bus_q;
        case (state_q)
            FCP_IDLE: begin
                if (start) begin
                    state_d = FCP_INSTR;
                    bus_d   = xfer_instr;
                end
            end
            FCP_INSTR: begin
                state_d = FCP_ADDR;
                bus_d   = addr_q;
            end
            FCP_ADDR:  state_d = FCP_END;
            default:   state_d = FCP_IDLE;
        endcase
        if (flush_req)
            state_d = FCP_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= FCP_IDLE;
            bus_q   <= INSTR_RST;
            addr_q  <= INSTR_RST;
            mem_q   <= 1'b0;
            fetch_q <= 1'b0;
            done_q  <= 1'b0;
            flush_q <= 1'b0;
        end else if (clk_en) begin
            flush_q <= flush_req;
            done_q  <= advance & (state_q == FCP_END);
            if (advance | flush_req) begin
                state_q <= state_d;
                bus_q   <= bus_d;
                fetch_q <= start & xfer_is_mem;
            end
            if (start) begin
                addr_q <= xfer_addr;
                mem_q  <= xfer_is_mem;
            end
        end
    end

    // Code valid and exceptions are sampled on every enabled cycle, codes only while valid, loaded data only on memory_data_strobe, held or not
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack_q  <= 1'b0;
            cc_q   <= CC_RST;
            ccv_q  <= 1'b0;
            load_q <= DATA_RST;
            memory_exception_q <= 1'b0;
        end else if (clk_en) begin
            ack_q  <= port.fp_exception_req & ~ack_q;
            ccv_q  <= port.fp_cond_code_valid;
            if (port.fp_cond_code_valid)
                cc_q <= port.fp_cond_code;
            if (memory_data_strobe)
                load_q <= port.sys_data;
            memory_exception_q <= memory_exception & memory_hold;
        end
    end

    assign port.coproc_bus         = bus_q;
    assign port.coproc_instr_valid = (state_q == FCP_INSTR);
    assign port.coproc_addr_valid  = (state_q == FCP_ADDR);
    assign port.coproc_xfer_end    = (state_q == FCP_END);
    assign port.data_fetch_ind     = fetch_q;
    assign port.fp_flush           = flush_q;
    assign port.fp_exception_ack   = ack_q;
    assign port.cpu_data_out       = store_data;
    assign port.cpu_data_oe        = store_data_oe & ~mem_q;

    assign xfer_ready     = (state_q == FCP_IDLE) & port.fpu_present;
    assign xfer_done      = done_q;
    assign load_data      = load_q;
    assign null_cycle_ind = any_hold;
    assign cond_code      = cc_q;
    assign cond_code_ok   = ccv_q;
    assign fp_exception   = ack_q;
    assign mem_exception  = memory_exception_q;
    assign unit_attached  = port.fpu_present;
endmodule // fcp_cpu_end

/* File: design/fcp_fpu_end.sv */
/*
 * Floating-point unit end of the coprocessor port. Captures instruction
 * and address, returns condition codes, raises exceptions, stalls the
 * processor, and moves operands over the shared data bus.
 * Assumes the user side supplies execution results synchronously.
 */
`timescale 1ns/1ps
module fcp_fpu_end (
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire logic                   clk_en,
    fcp_if.fpu                          port,
    input  wire logic                   present,
    input  wire logic                   busy,
    output logic [fcp_pkg::INSTR_W-1:0] instr,
    output logic [fcp_pkg::INSTR_W-1:0] instr_addr,
    output logic                        instr_new,
    output logic                        instr_mem,
    output logic                        flushed,
    input  wire logic [fcp_pkg::CC_W-1:0] result_cc,
    input  wire logic                   result_cc_valid,
    input  wire logic                   raise_exc,
    input  wire logic [fcp_pkg::DATA_W-1:0] store_operand,
    input  wire logic                   store_operand_oe,
    input  wire logic                   load_strobe,
    output logic [fcp_pkg::DATA_W-1:0]  load_operand
);
    import fcp_pkg::*;

    logic [INSTR_W-1:0] instr_q;
    logic [INSTR_W-1:0] addr_q;
    logic               new_q;
    logic               mem_q;
    logic               pend_q;
    logic               exc_q;
    logic [CC_W-1:0]    cc_q;
    logic               ccv_q;
    logic [DATA_W-1:0]  ld_q;

    wire exc_d = (exc_q & ~port.fp_exception_ack) | raise_exc;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            instr_q <= INSTR_RST;
            addr_q  <= INSTR_RST;
            new_q   <= 1'b0;
            mem_q   <= 1'b0;
            pend_q  <= 1'b0;
            exc_q   <= 1'b0;
            cc_q    <= CC_RST;
            ccv_q   <= 1'b0;
            ld_q    <= DATA_RST;
        end else if (clk_en) begin
            new_q <= port.coproc_xfer_end & pend_q & ~port.fp_flush;
            if (port.coproc_instr_valid) begin
                instr_q <= port.coproc_bus;
                mem_q   <= port.data_fetch_ind;
                pend_q  <= 1'b1;
            end
            if (port.coproc_addr_valid)
                addr_q <= port.coproc_bus;
            if (port.fp_flush | port.coproc_xfer_end)
                pend_q <= 1'b0;
            exc_q <= exc_d;
            ccv_q <= result_cc_valid;
            if (result_cc_valid)
                cc_q <= result_cc;
            if (load_strobe)
                ld_q <= port.sys_data;
        end
    end

    assign port.fp_cond_code       = cc_q;
    assign port.fp_cond_code_valid = ccv_q;
    assign port.fp_exception_req   = exc_q;
    assign port.coproc_hold        = busy & present;
    assign port.fpu_present        = present;
    assign port.fpu_data_out       = store_operand;
    assign port.fpu_data_oe        = store_operand_oe & present;

    assign instr      = instr_q;
    assign instr_addr = addr_q;
    assign instr_new  = new_q;
    assign instr_mem  = mem_q;
    assign flushed    = port.fp_flush;
    assign load_operand = ld_q;
endmodule // fcp_fpu_end

/* File: sim/fcp_port_assertions.sv */
/* Checker on the coprocessor port wires: strobe order, hold, exceptions.
   Assumes one clock, sys_clk, and instantiation beside the interface. */
`timescale 1ns/1ps
module fcp_port_assertions (
    input wire logic                        sys_clk,
    input wire logic                        srst,
    input wire logic [fcp_pkg::INSTR_W-1:0] coproc_bus,
    input wire logic                        coproc_instr_valid,
    input wire logic                        coproc_addr_valid,
    input wire logic                        coproc_xfer_end,
    input wire logic                        data_fetch_ind,
    input wire logic                        fp_flush,
    input wire logic                        fp_exception_req,
    input wire logic                        fp_exception_ack,
    input wire logic                        coproc_hold,
    input wire logic                        fpu_present
);
    import fcp_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_instr; coproc_instr_valid && !coproc_hold; endsequence
    sequence s_addr; coproc_addr_valid && !coproc_hold; endsequence
    sequence s_end; coproc_xfer_end && !coproc_hold; endsequence
    // Flush may cut the instruction cycle short
    a_instr_then_addr: assert property (
        s_instr |=> (coproc_addr_valid or ##[0:1] fp_flush))
        else $error("address cycle missing");
    a_addr_then_end: assert property (
        s_addr |=> coproc_xfer_end)
        else $error("end cycle missing");
    a_end_one_cycle: assert property (
        s_end |=> !(coproc_instr_valid || coproc_addr_valid
                    || coproc_xfer_end))
        else $error("end not last cycle");
    a_strobe_onehot: assert property (
        $onehot0({coproc_instr_valid, coproc_addr_valid, coproc_xfer_end}))
        else $error("strobes overlap");
    a_hold_stretch: assert property (
        coproc_hold && coproc_instr_valid
        |=> coproc_instr_valid && $stable(coproc_bus))
        else $error("hold not honoured");
    a_fetch_in_instr: assert property (
        data_fetch_ind |-> coproc_instr_valid)
        else $error("data fetch outside instruction cycle");
    a_exc_acked: assert property (
        $rose(fp_exception_req) |=> fp_exception_ack)
        else $error("exception not acknowledged");
    a_ack_drops_req: assert property (
        fp_exception_ack |=> !fp_exception_req && !fp_exception_ack)
        else $error("request kept after ack");
    a_absent_quiet: assert property (
        !fpu_present |-> !coproc_instr_valid && !coproc_hold)
        else $error("activity without unit");
endmodule // fcp_port_assertions

/* File: sim/float_coprocessor_port_tb.sv */
/* Testbench joining processor end and unit end through the interface.
   Assumes the design package and interface are compiled first. */
`timescale 1ns/1ps
module float_coprocessor_port_tb;
    import fcp_pkg::*;
    logic               sys_clk, srst, clk_en, xfer_req, xfer_is_mem;
    logic               flush_req, store_data_oe, memory_hold, present;
    logic               memory_data_strobe, memory_exception, busy;
    logic               result_cc_valid, raise_exc, store_operand_oe;
    logic               load_strobe, xfer_ready, xfer_done, flushed;
    logic               null_cycle_ind, cond_code_ok, fp_exception;
    logic               mem_exception, unit_attached, instr_new, instr_mem;
    logic [CC_W-1:0]    result_cc, cond_code;
    logic [INSTR_W-1:0] xfer_instr, xfer_addr, instr, instr_addr;
    logic [DATA_W-1:0]  store_data, load_data, store_operand, load_operand;
    logic [31:0]        rnd;
    logic [64:0]        ex;
    logic [64:0]        xq[$];
    logic [64:0]        cq[$];
    int                 errors = 0, samples_checked = 0, cyc = 0, n, i;

    fcp_if port ();
    fcp_cpu_end i_fcp_cpu_end (.*);
    fcp_fpu_end i_fcp_fpu_end (.*);
    fcp_port_assertions i_fcp_port_assertions (.sys_clk(sys_clk),
        .srst(srst), .coproc_bus(port.coproc_bus),
        .coproc_instr_valid(port.coproc_instr_valid),
        .coproc_addr_valid(port.coproc_addr_valid),
        .coproc_xfer_end(port.coproc_xfer_end),
        .data_fetch_ind(port.data_fetch_ind), .fp_flush(port.fp_flush),
        .fp_exception_req(port.fp_exception_req),
        .fp_exception_ack(port.fp_exception_ack),
        .coproc_hold(port.coproc_hold), .fpu_present(port.fpu_present));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction

    task automatic check(input string nm, input logic [64:0] s, e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_of_test;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic xfer(input logic m, input int hb);
        @(negedge sys_clk);
        check("xfer_ready", xfer_ready, 1);
        @(posedge sys_clk);
        rnd = lfsr(rnd);
        xfer_instr <= rnd;
        xq.push_back({m, rnd, lfsr(rnd)});
        rnd = lfsr(rnd);
        xfer_addr <= rnd;
        xfer_is_mem <= m;
        xfer_req <= 1'b1;
        @(posedge sys_clk);
        xfer_req <= 1'b0;
        n = 0;
        // Hold cycles are counted so an ignored hold shows as early done
        if (hb > 0) begin
            busy <= 1'b1;
            repeat (hb) begin
                @(posedge sys_clk);
                n++;
            end
            busy <= 1'b0;
        end
        do begin
            @(negedge sys_clk);
            n++;
        end while (xfer_done !== 1'b1 && n < 20);
        check("done_cycles", n, 4 + hb);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Timeout well above the hundred or so cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_of_test();
        end
    end

    // Unexpected results find an empty queue and compare against unknown
    always @(negedge sys_clk) begin
        if (instr_new === 1'b1) begin
            ex = xq.size() ? xq.pop_front() : 'x;
            check("instr", {instr_mem, instr, instr_addr}, ex);
        end
        if (cond_code_ok === 1'b1) begin
            ex = cq.size() ? cq.pop_front() : 'x;
            check("cond_code", cond_code, ex);
        end
    end

    initial begin
        {xfer_req, xfer_is_mem, flush_req, store_data_oe, memory_hold,
         memory_data_strobe, memory_exception, busy, result_cc_valid,
         raise_exc, store_operand_oe, load_strobe, result_cc, xfer_instr,
         xfer_addr, store_data, store_operand} = '0;
        present = 1'b1;
        clk_en = 1'b1;
        srst = 1'b1;
        rnd = 32'h0001_430a;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        // Last one is a plain operate so the processor may drive data after
        for (i = 0; i < 6; i++) xfer(~i[0], i % 3);
        for (i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            result_cc <= i[1:0];
            result_cc_valid <= 1'b1;
            cq.push_back(i[1:0]);
            @(posedge sys_clk);
            result_cc_valid <= 1'b0;
        end
        @(posedge sys_clk);
        rnd = lfsr(rnd);
        store_operand <= rnd;
        store_operand_oe <= 1'b1;
        memory_data_strobe <= 1'b1;
        @(posedge sys_clk);
        store_operand_oe <= 1'b0;
        memory_data_strobe <= 1'b0;
        @(negedge sys_clk);
        check("load_data", load_data, rnd);
        @(posedge sys_clk);
        rnd = lfsr(rnd);
        store_data <= rnd;
        store_data_oe <= 1'b1;
        load_strobe <= 1'b1;
        @(posedge sys_clk);
        store_data_oe <= 1'b0;
        load_strobe <= 1'b0;
        @(negedge sys_clk);
        check("load_operand", load_operand, rnd);
        @(posedge sys_clk);
        memory_hold <= 1'b1;
        memory_exception <= 1'b1;
        @(negedge sys_clk);
        check("null_cycle", null_cycle_ind, 1);
        @(posedge sys_clk);
        memory_hold <= 1'b0;
        memory_exception <= 1'b0;
        @(negedge sys_clk);
        check("mem_exception", mem_exception, 1);
        @(posedge sys_clk);
        raise_exc <= 1'b1;
        @(posedge sys_clk);
        raise_exc <= 1'b0;
        for (n = 0; n < 6 && fp_exception !== 1'b1; n++) @(negedge sys_clk);
        check("fp_exception", fp_exception, 1);
        @(posedge sys_clk);
        xfer_req <= 1'b1;
        @(posedge sys_clk);
        xfer_req <= 1'b0;
        flush_req <= 1'b1;
        @(posedge sys_clk);
        flush_req <= 1'b0;
        for (n = 0; n < 6 && flushed !== 1'b1; n++) @(negedge sys_clk);
        check("flushed", flushed, 1);
        xfer(1'b0, 0);
        @(posedge sys_clk);
        present <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check("attached", unit_attached, 0);
        check("ready", xfer_ready, 0);
        @(posedge sys_clk);
        present <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check("pending", xq.size() + cq.size(), 0);
        end_of_test();
    end
endmodule // float_coprocessor_port_tb
